//--- hw/stsc_pkg.sv
`default_nettype none
package stsc_pkg;

  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned BLINK_MS = 250;
  localparam int unsigned BLINK_CYCLES = CLK_HZ / 1000 * BLINK_MS;
  localparam logic [1:0] CAPTURE_EDGES = 2'h2;

  // ----------------------------------------
  // switch bank positions (index 0 is position one)
  // ----------------------------------------
  localparam int SW_W = 10;
  localparam int SW_BAUD3 = 0;
  localparam int SW_BAUD2 = 1;
  localparam int SW_BAUD1 = 2;
  localparam int SW_BAUD0 = 3;
  localparam int SW_DATA8 = 4;
  localparam int SW_PAR_EN = 5;
  localparam int SW_PAR_ODD = 6;
  localparam int SW_STOP2 = 7;
  localparam int SW_SUPER = 9;

  // ----------------------------------------
  // baud rates and bit-period divisors
  // ----------------------------------------
  localparam int unsigned BAUD_1200 = 1200;
  localparam int unsigned BAUD_2400 = 2400;
  localparam int unsigned BAUD_4800 = 4800;
  localparam int unsigned BAUD_7200 = 7200;
  localparam int unsigned BAUD_9600 = 9600;
  localparam int unsigned BAUD_14400 = 14400;
  localparam int unsigned BAUD_19200 = 19200;
  localparam int unsigned BAUD_28800 = 28800;
  localparam int unsigned BAUD_38400 = 38400;
  localparam int unsigned BAUD_57600 = 57600;
  localparam int unsigned BAUD_31250 = 31250;
  localparam logic [3:0] BAUD_CODE_MAX = 4'hA;
  localparam logic [15:0] DIV_1200 = 16'(CLK_HZ / BAUD_1200);
  localparam logic [15:0] DIV_31250 = 16'(CLK_HZ / BAUD_31250);

  function automatic logic [15:0] stsc_baud_div(input logic [3:0] code);
    logic [15:0] d;
    d = DIV_1200;
    unique case (code)
      4'h1: d = 16'(CLK_HZ / BAUD_2400);
      4'h2: d = 16'(CLK_HZ / BAUD_4800);
      4'h3: d = 16'(CLK_HZ / BAUD_7200);
      4'h4: d = 16'(CLK_HZ / BAUD_9600);
      4'h5: d = 16'(CLK_HZ / BAUD_14400);
      4'h6: d = 16'(CLK_HZ / BAUD_19200);
      4'h7: d = 16'(CLK_HZ / BAUD_28800);
      4'h8: d = 16'(CLK_HZ / BAUD_38400);
      4'h9: d = 16'(CLK_HZ / BAUD_57600);
      4'hA: d = DIV_31250;
      default: d = DIV_1200;
    endcase
    return d;
  endfunction : stsc_baud_div

  // ----------------------------------------
  // tunnel slots and types
  // ----------------------------------------
  localparam int NUM_SLOTS = 14;
  localparam logic [3:0] SLOT_LAST = 4'hD;
  localparam logic [3:0] SLOT_PAIR_LAST = 4'hC;
  typedef enum logic [1:0] {
    TT_MIDI_IN = 2'h0,
    TT_MIDI_OUT = 2'h1,
    TT_RS232 = 2'h2,
    TT_GPIO = 2'h3
  } stsc_tun_e;

  // ----------------------------------------
  // register indices and fields
  // ----------------------------------------
  localparam logic [3:0] REG_CONFIG = 4'h0;
  localparam logic [3:0] REG_DIV = 4'h1;
  localparam logic [3:0] REG_SLOT_OCC = 4'h2;
  localparam logic [3:0] REG_REQ = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_RELEASE = 4'h5;
  localparam logic [3:0] REG_GPIO_OUT = 4'h6;
  localparam logic [3:0] REG_GPIO_IN = 4'h7;
  localparam logic [3:0] REG_PANEL = 4'h8;
  localparam int CFG_SUPER_BIT = 8;
  localparam int CFG_INVALID_BIT = 9;
  localparam int REQ_SLOT_LSB = 0;
  localparam int REQ_TYPE_LSB = 4;
  localparam int REQ_GO_BIT = 8;
  localparam int STAT_GRANT_BIT = 0;
  localparam int STAT_REFUSE_BIT = 1;
  localparam int STAT_MIDI_BIT = 2;
  localparam int STAT_MSLOT_LSB = 4;
  localparam logic [3:0] GPIO_OUT_RST = 4'h0;
  localparam logic [3:0] PANEL_SLOT_RST = 4'h0;

endpackage : stsc_pkg
`default_nettype wire

//--- hw/stsc_sync.sv
`timescale 1ns/10ps
`default_nettype none
module stsc_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_r <= '0;
      q_o <= '0;
    end
    else
    begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule : stsc_sync
`default_nettype wire

//--- hw/stsc_top.sv
`timescale 1ns/10ps
`default_nettype none
module stsc_top
  import stsc_pkg::*;
#(
  parameter int unsigned BLINK_CYC = BLINK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [SW_W-1:0] sw_i,
  input wire logic btn_midi_i,
  input wire logic btn_confirm_i,
  input wire logic btn_cancel_i,
  input wire logic factory_i,
  input wire logic [3:0] gpio_in_i,
  input wire logic [3:0] gpio_mode_i,
  input wire logic [7:0] midi_in_byte_i,
  input wire logic midi_in_valid_i,
  input wire logic [7:0] tun_rx_data_i,
  input wire logic tun_rx_valid_i,
  input wire logic [3:0] tun_rx_slot_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic [15:0] baud_div_o,
  output logic data8_o,
  output logic parity_en_o,
  output logic parity_odd_o,
  output logic stop2_o,
  output logic super_led_o,
  output logic [NUM_SLOTS-1:0] in_use_led_o,
  output logic bcast_valid_o,
  output logic [3:0] bcast_slot_o,
  output logic [7:0] tun_tx_data_o,
  output logic tun_tx_valid_o,
  output logic [3:0] tun_tx_slot_o,
  output logic [7:0] midi_out_byte_o,
  output logic midi_out_valid_o,
  output logic [3:0] gpio_out_o,
  output logic midi_led_o,
  output logic confirm_led_o
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [SW_W-1:0] sw_s;
  logic [3:0] btn_s;
  logic [7:0] gpio_s;
  stsc_sync #(.W(SW_W)) u_sync_sw (.clk_i(clk_i), .rst_i(rst_i), .d_i(sw_i), .q_o(sw_s));
  stsc_sync #(.W(4)) u_sync_btn (.clk_i(clk_i), .rst_i(rst_i),
    .d_i({factory_i, btn_cancel_i, btn_confirm_i, btn_midi_i}), .q_o(btn_s));
  stsc_sync #(.W(8)) u_sync_gpio (.clk_i(clk_i), .rst_i(rst_i),
    .d_i({gpio_mode_i, gpio_in_i}), .q_o(gpio_s));

  // ----------------------------------------
  // switch decode and role capture
  // ----------------------------------------
  logic [3:0] code;
  logic invalid_r, invalid_nxt, captured_r, captured_nxt;
  logic [3:0] code_r, code_nxt;
  logic [15:0] div_nxt;
  logic d8_nxt, pe_nxt, po_nxt, s2_nxt, role_nxt;
  logic [1:0] cap_cnt_r, cap_cnt_nxt;

  always_comb
  begin
    code = {sw_s[SW_BAUD3], sw_s[SW_BAUD2], sw_s[SW_BAUD1], sw_s[SW_BAUD0]};
    code_nxt = code;
    invalid_nxt = code > BAUD_CODE_MAX;
    div_nxt = stsc_baud_div(invalid_nxt ? 4'h0 : code);
    // positions nine and ten never reach the framing outputs
    d8_nxt = sw_s[SW_DATA8];
    pe_nxt = sw_s[SW_PAR_EN];
    po_nxt = sw_s[SW_PAR_ODD];
    s2_nxt = sw_s[SW_STOP2];
    cap_cnt_nxt = cap_cnt_r;
    captured_nxt = captured_r;
    role_nxt = super_led_o;
    // wait until the synchroniser holds the real strap level
    if (cap_cnt_r != CAPTURE_EDGES)
      cap_cnt_nxt = cap_cnt_r + 2'h1;
    else if (!captured_r)
    begin
      role_nxt = sw_s[SW_SUPER];
      captured_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      code_r <= 4'h0;
      invalid_r <= 1'b0;
      baud_div_o <= DIV_1200;
      data8_o <= 1'b0;
      parity_en_o <= 1'b0;
      parity_odd_o <= 1'b0;
      stop2_o <= 1'b0;
      cap_cnt_r <= 2'h0;
      captured_r <= 1'b0;
      super_led_o <= 1'b0;
    end
    else
    begin
      code_r <= code_nxt;
      invalid_r <= invalid_nxt;
      baud_div_o <= div_nxt;
      data8_o <= d8_nxt;
      parity_en_o <= pe_nxt;
      parity_odd_o <= po_nxt;
      stop2_o <= s2_nxt;
      cap_cnt_r <= cap_cnt_nxt;
      captured_r <= captured_nxt;
      super_led_o <= role_nxt;
    end
  end

  // ----------------------------------------
  // front panel MIDI-in assignment
  // ----------------------------------------
  typedef enum logic [1:0] {PNL_IDLE = 2'b01, PNL_PEND = 2'b10} stsc_pnl_e;
  stsc_pnl_e pnl_r, pnl_nxt;
  logic [2:0] btn_prev_r, btn_rise;
  logic [3:0] pnl_slot_r, pnl_slot_nxt;
  logic [31:0] blink_cnt_r, blink_cnt_nxt;
  logic blink_r, blink_nxt, flash, pnl_commit;

  always_comb
  begin
    btn_rise = btn_s[2:0] & ~btn_prev_r;
    pnl_nxt = pnl_r;
    pnl_commit = 1'b0;
    pnl_slot_nxt = (wr_i && addr_i == REG_PANEL) ? wdata_i[3:0] : pnl_slot_r;
    unique case (pnl_r)
      PNL_IDLE:
        if (btn_rise[0])
          pnl_nxt = PNL_PEND;
      PNL_PEND:
        if (btn_rise[1])
        begin
          pnl_commit = 1'b1;
          pnl_nxt = PNL_IDLE;
        end
        else if (btn_rise[2])
          pnl_nxt = PNL_IDLE;
      default: pnl_nxt = PNL_IDLE;
    endcase
    // long blink period is a parameter so simulation can shorten it
    blink_cnt_nxt = blink_cnt_r + 32'h1;
    blink_nxt = blink_r;
    if (blink_cnt_r >= BLINK_CYC - 1)
    begin
      blink_cnt_nxt = 32'h0;
      blink_nxt = ~blink_r;
    end
    flash = (pnl_nxt == PNL_PEND) && blink_nxt;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pnl_r <= PNL_IDLE;
      btn_prev_r <= 3'h0;
      pnl_slot_r <= PANEL_SLOT_RST;
      blink_cnt_r <= 32'h0;
      blink_r <= 1'b0;
      midi_led_o <= 1'b0;
      confirm_led_o <= 1'b0;
    end
    else
    begin
      pnl_r <= pnl_nxt;
      btn_prev_r <= btn_s[2:0];
      pnl_slot_r <= pnl_slot_nxt;
      blink_cnt_r <= blink_cnt_nxt;
      blink_r <= blink_nxt;
      midi_led_o <= flash;
      confirm_led_o <= flash;
    end
  end

  // ----------------------------------------
  // tunnel slot allocator
  // ----------------------------------------
  // no audio rate, channel or gain input exists here; transport is independent
  logic req_v, slot_ok, gnt, gnt_in, midi_bound_r, midi_bound_nxt;
  logic [3:0] req_slot, midi_slot_r, midi_slot_nxt;
  stsc_tun_e req_type;
  logic [NUM_SLOTS-1:0] need, clr, occ_nxt, outb_r, outb_nxt;
  logic grant_r, grant_nxt, refuse_r, refuse_nxt, bc_v_nxt;
  logic [3:0] bc_slot_nxt;

  always_comb
  begin
    // a panel commit takes the cycle; a register request beside it is refused
    req_v = pnl_commit | (wr_i && addr_i == REG_REQ && wdata_i[REQ_GO_BIT]);
    req_slot = pnl_commit ? pnl_slot_r : wdata_i[REQ_SLOT_LSB +: 4];
    req_type = pnl_commit ? TT_MIDI_IN : stsc_tun_e'(wdata_i[REQ_TYPE_LSB +: 2]);
    need = NUM_SLOTS'(1) << req_slot;
    if (req_type == TT_RS232)
      need = need | (need << 1);
    slot_ok = (req_type == TT_RS232) ? req_slot <= SLOT_PAIR_LAST : req_slot <= SLOT_LAST;
    gnt = 1'b0;
    unique case (req_type)
      TT_MIDI_OUT: gnt = slot_ok;
      TT_MIDI_IN: gnt = super_led_o && slot_ok && !(|(in_use_led_o & need)) && !midi_bound_r;
      default: gnt = super_led_o && slot_ok && !(|(in_use_led_o & need));
    endcase
    gnt = gnt && req_v;
    gnt_in = gnt && req_type != TT_MIDI_OUT;
    // release first, then grant, so a set in the same cycle wins
    clr = (wr_i && addr_i == REG_RELEASE) ? wdata_i[NUM_SLOTS-1:0] : '0;
    if (btn_s[3])
      clr = '1;
    occ_nxt = in_use_led_o & ~clr;
    outb_nxt = outb_r & ~clr;
    midi_bound_nxt = midi_bound_r && !clr[midi_slot_r];
    midi_slot_nxt = midi_slot_r;
    if (gnt_in)
      occ_nxt = occ_nxt | need;
    if (gnt && req_type == TT_MIDI_OUT)
      outb_nxt = outb_nxt | need;
    if (gnt && req_type == TT_MIDI_IN)
    begin
      midi_bound_nxt = 1'b1;
      midi_slot_nxt = req_slot;
    end
    grant_nxt = req_v ? gnt : grant_r;
    refuse_nxt = req_v ? !gnt : refuse_r;
    if (pnl_commit && wr_i && addr_i == REG_REQ && wdata_i[REQ_GO_BIT])
      refuse_nxt = 1'b1;
    bc_v_nxt = gnt_in;
    bc_slot_nxt = gnt_in ? req_slot : bcast_slot_o;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      in_use_led_o <= '0;
      outb_r <= '0;
      midi_bound_r <= 1'b0;
      midi_slot_r <= 4'h0;
      grant_r <= 1'b0;
      refuse_r <= 1'b0;
      bcast_valid_o <= 1'b0;
      bcast_slot_o <= 4'h0;
    end
    else
    begin
      in_use_led_o <= occ_nxt;
      outb_r <= outb_nxt;
      midi_bound_r <= midi_bound_nxt;
      midi_slot_r <= midi_slot_nxt;
      grant_r <= grant_nxt;
      refuse_r <= refuse_nxt;
      bcast_valid_o <= bc_v_nxt;
      bcast_slot_o <= bc_slot_nxt;
    end
  end

  // ----------------------------------------
  // byte paths, GPIO and register reads
  // ----------------------------------------
  logic [3:0] gpio_sense, gpio_in_r, gpio_out_nxt;
  logic [31:0] rdata_nxt;

  always_comb
  begin
    // isolated contact closure pulls the sensed line low
    gpio_sense = gpio_s[3:0] ^ gpio_s[7:4];
    gpio_out_nxt = (wr_i && addr_i == REG_GPIO_OUT) ? wdata_i[3:0] : gpio_out_o;
    rdata_nxt = 32'h0;
    if (rd_i)
    begin
      unique case (addr_i)
        REG_CONFIG: rdata_nxt = {22'h0, invalid_r, super_led_o, stop2_o, parity_odd_o,
                                 parity_en_o, data8_o, code_r};
        REG_DIV: rdata_nxt = {16'h0, baud_div_o};
        REG_SLOT_OCC: rdata_nxt = {18'h0, in_use_led_o};
        REG_STATUS: rdata_nxt = {24'h0, midi_slot_r, 1'b0, midi_bound_r, refuse_r, grant_r};
        REG_GPIO_OUT: rdata_nxt = {28'h0, gpio_out_o};
        REG_GPIO_IN: rdata_nxt = {28'h0, gpio_in_r};
        REG_PANEL: rdata_nxt = {28'h0, pnl_slot_r};
        default: rdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tun_tx_data_o <= 8'h0;
      tun_tx_valid_o <= 1'b0;
      tun_tx_slot_o <= 4'h0;
      midi_out_byte_o <= 8'h0;
      midi_out_valid_o <= 1'b0;
      gpio_in_r <= 4'h0;
      gpio_out_o <= GPIO_OUT_RST;
      rdata_o <= 32'h0;
    end
    else
    begin
      tun_tx_data_o <= midi_in_byte_i;
      tun_tx_valid_o <= midi_in_valid_i && midi_bound_r;
      tun_tx_slot_o <= midi_slot_r;
      midi_out_byte_o <= tun_rx_data_i;
      midi_out_valid_o <= tun_rx_valid_i && tun_rx_slot_i <= SLOT_LAST && outb_r[tun_rx_slot_i];
      gpio_in_r <= gpio_sense;
      gpio_out_o <= gpio_out_nxt;
      rdata_o <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_role_frozen: assert property (captured_r && $past(captured_r) |-> $stable(super_led_o))
    else $error("role changed after capture");
  a_role_sample: assert property (cap_cnt_r == CAPTURE_EDGES && !captured_r
    |=> super_led_o == $past(sw_s[SW_SUPER]) && captured_r)
    else $error("role not taken from switch ten");
  a_baud_fallback: assert property (invalid_r |-> baud_div_o == DIV_1200)
    else $error("invalid code not at 1200");
  a_baud_midi: assert property (!invalid_r && code_r == 4'hA |-> baud_div_o == DIV_31250)
    else $error("midi code wrong divisor");
  a_serial_pair: assert property (gnt && req_type == TT_RS232
    |=> (in_use_led_o & $past(need)) == $past(need) && $countones($past(need)) == 2)
    else $error("serial session not two slots");
  a_no_grant: assert property (req_v && !super_led_o && req_type != TT_MIDI_OUT
    |=> !grant_r && refuse_r)
    else $error("grant without supervisor role");
  a_midi_once: assert property (midi_bound_r && req_v && req_type == TT_MIDI_IN |=> refuse_r)
    else $error("second midi input bound");
  a_midi_pass: assert property (midi_bound_r && midi_in_valid_i
    |=> tun_tx_valid_o && tun_tx_data_o == $past(midi_in_byte_i))
    else $error("midi byte altered or lost");
  a_cancel_drop: assert property (pnl_r == PNL_PEND && btn_rise[2] && !btn_rise[1]
    |=> pnl_r == PNL_IDLE ##1 !midi_led_o)
    else $error("cancel did not abandon");
  a_bcast_slot: assert property (gnt_in |=> bcast_valid_o && in_use_led_o[bcast_slot_o])
    else $error("assignment not broadcast");

endmodule : stsc_top
`default_nettype wire

//--- tb/stsc_midi_dev.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// external midi / serial equipment
// ----------------------------------------
module stsc_midi_dev (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic send_i,
  input wire logic [7:0] send_byte_i,
  input wire logic [15:0] own_div_i,
  input wire logic [15:0] port_div_i,
  output logic [7:0] byte_o,
  output logic valid_o,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_valid_i,
  output logic [7:0] rx_seen_o
);
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      byte_o <= 8'h00;
      valid_o <= 1'b0;
      rx_seen_o <= 8'h00;
    end
    else
    begin
      // silent unless both ends run the same rate
      valid_o <= send_i && (own_div_i == port_div_i);
      // line not held after the pulse, so stale data cannot pass for good
      byte_o <= send_i ? send_byte_i : ~byte_o;
      if (rx_valid_i)
      begin
        rx_seen_o <= rx_byte_i;
      end
    end
  end
endmodule : stsc_midi_dev
`default_nettype wire

//--- tb/test_serial_tunnel_switch_config.sv
`timescale 1ns/10ps
`default_nettype none
module test_serial_tunnel_switch_config;
  import stsc_pkg::*;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [9:0] sw_i = 10'h200;
  logic [2:0] btn = 3'h0;
  logic factory_i = 1'b0;
  logic [3:0] gpio_in_i = 4'h0, gpio_mode_i = 4'h0, addr_i = 4'h0, tun_rx_slot_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0, rd_i = 1'b0, tun_rx_valid_i = 1'b0, send = 1'b0;
  logic [7:0] tun_rx_data_i = 8'h00, send_byte = 8'h00;
  logic [15:0] own_div = 16'h0;
  wire [7:0] midi_in_byte_i;
  wire midi_in_valid_i;
  logic [31:0] rdata_o;
  logic [15:0] baud_div_o;
  logic data8_o, parity_en_o, parity_odd_o, stop2_o, super_led_o, bcast_valid_o;
  logic tun_tx_valid_o, midi_out_valid_o, midi_led_o, confirm_led_o;
  logic [13:0] in_use_led_o;
  logic [3:0] bcast_slot_o, tun_tx_slot_o, gpio_out_o;
  logic [7:0] tun_tx_data_o, midi_out_byte_o, rx_seen;
  int fails = 0;
  int tests_run = 0;

  stsc_top #(.BLINK_CYC(4)) uut (.clk_i, .rst_i, .sw_i, .btn_midi_i(btn[0]),
    .btn_confirm_i(btn[1]), .btn_cancel_i(btn[2]), .factory_i, .gpio_in_i, .gpio_mode_i,
    .midi_in_byte_i, .midi_in_valid_i, .tun_rx_data_i, .tun_rx_valid_i, .tun_rx_slot_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .baud_div_o, .data8_o, .parity_en_o,
    .parity_odd_o, .stop2_o, .super_led_o, .in_use_led_o, .bcast_valid_o, .bcast_slot_o,
    .tun_tx_data_o, .tun_tx_valid_o, .tun_tx_slot_o, .midi_out_byte_o, .midi_out_valid_o,
    .gpio_out_o, .midi_led_o, .confirm_led_o);

  stsc_midi_dev dev (.clk_i, .rst_i, .send_i(send), .send_byte_i(send_byte),
    .own_div_i(own_div), .port_div_i(baud_div_o), .byte_o(midi_in_byte_i),
    .valid_o(midi_in_valid_i), .rx_byte_i(midi_out_byte_o), .rx_valid_i(midi_out_valid_o),
    .rx_seen_o(rx_seen));

  always #20 clk_i = ~clk_i;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  function automatic logic [15:0] exp_div(input int code);
    int rate [11] = '{1200, 2400, 4800, 7200, 9600, 14400, 19200, 28800, 38400, 57600, 31250};
    return 16'(25000000 / rate[(code > 10) ? 0 : code]);
  endfunction : exp_div

  task automatic finish_test;
    if (fails == 0 && tests_run > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wreg

  task automatic rreg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rreg

  task automatic req(input logic [3:0] s, input stsc_tun_e t, input logic g);
    logic [31:0] d;
    wreg(REG_REQ, 32'h100 | (32'(t) << 4) | 32'(s));
    chk("bcast", 32'(bcast_valid_o), 32'(g && t != TT_MIDI_OUT));
    if (g && t != TT_MIDI_OUT)
    begin
      chk("bslot", 32'(bcast_slot_o), 32'(s));
    end
    rreg(REG_STATUS, d);
    chk("status", d & 32'h3, g ? 32'h1 : 32'h2);
  endtask : req

  task automatic do_reset(input logic sup);
    @(posedge clk_i);
    rst_i <= 1'b1;
    sw_i[9] <= sup;
    repeat (5) @(posedge clk_i);
    #1;
    chk("rst div", 32'(baud_div_o), 32'h5161);
    chk("rst leds", 32'({super_led_o, in_use_led_o}), 32'h0);
    @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    chk("role", 32'(super_led_o), 32'(sup));
  endtask : do_reset

  task automatic press(input int k);
    @(posedge clk_i);
    btn[k] <= 1'b1;
    repeat (5) @(posedge clk_i);
    btn[k] <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
  endtask : press

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    int n;
    logic [31:0] d, cfg;
    logic [7:0] b;
    n = $urandom(32'hF9BD);
    do_reset(1'b1);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk_i);
      sw_i <= {1'($urandom), 1'($urandom), 4'($urandom), i[0], i[1], i[2], i[3]};
      repeat (4) @(posedge clk_i);
      #1;
      chk("div", 32'(baud_div_o), 32'(exp_div(i)));
      chk("frame", 32'({stop2_o, parity_odd_o, parity_en_o, data8_o}), 32'(sw_i[7:4]));
      chk("held role", 32'(super_led_o), 32'h1);
      rreg(REG_CONFIG, d);
      chk("config", d & 32'h3FF, 32'({i > 10, 1'b1, sw_i[7:4], i[3:0]}));
    end
    @(posedge clk_i);
    sw_i[3:0] <= 4'h9;
    own_div <= exp_div(9);
    repeat (4) @(posedge clk_i);
    req(4'h4, TT_RS232, 1'b1);
    chk("pair", 32'(in_use_led_o[5:4]), 32'h3);
    req(4'h5, TT_RS232, 1'b0);
    req(4'hD, TT_RS232, 1'b0);
    for (int s = 0; s < 13; s += 2)
    begin
      if (s != 4)
      begin
        req(4'(s), TT_RS232, 1'b1);
      end
    end
    chk("full", 32'(in_use_led_o), 32'h3FFF);
    rreg(REG_SLOT_OCC, d);
    chk("occ reg", d, 32'h3FFF);
    req(4'h1, TT_GPIO, 1'b0);
    wreg(REG_RELEASE, 32'h3FFF);
    chk("released", 32'(in_use_led_o), 32'h0);
    req(4'hB, TT_GPIO, 1'b1);
    req(4'h3, TT_MIDI_IN, 1'b1);
    req(4'h6, TT_MIDI_IN, 1'b0);
    req(4'h3, TT_MIDI_OUT, 1'b1);
    rreg(REG_STATUS, d);
    chk("midi bound", d & 32'hF4, 32'h34);
    chk("in use", 32'(in_use_led_o), 32'h0808);
    repeat (8)
    begin
      b = 8'($urandom);
      @(posedge clk_i);
      send <= 1'b1;
      send_byte <= b;
      @(posedge clk_i);
      send <= 1'b0;
      @(posedge clk_i);
      #1;
      chk("tx", 32'({tun_tx_valid_o, tun_tx_slot_o, tun_tx_data_o}), 32'({5'h13, b}));
      @(posedge clk_i);
      tun_rx_data_i <= b;
      tun_rx_slot_i <= 4'h3;
      tun_rx_valid_i <= 1'b1;
      @(posedge clk_i);
      tun_rx_valid_i <= 1'b0;
      tun_rx_data_i <= ~b;
      #1;
      chk("rx", 32'({midi_out_valid_o, midi_out_byte_o}), 32'({1'b1, b}));
      @(posedge clk_i);
      #1;
      chk("dev rx", 32'(rx_seen), 32'(b));
    end
    rreg(REG_CONFIG, cfg);
    @(posedge clk_i);
    factory_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    factory_i <= 1'b0;
    #1;
    chk("factory occ", 32'(in_use_led_o), 32'h0);
    rreg(REG_CONFIG, d);
    chk("factory cfg", d, cfg);
    rreg(REG_STATUS, d);
    chk("factory midi", d & 32'h4, 32'h0);
    d = 32'($urandom);
    wreg(REG_GPIO_OUT, d);
    chk("gpio out", 32'(gpio_out_o), d & 32'hF);
    @(posedge clk_i);
    gpio_in_i <= 4'($urandom);
    gpio_mode_i <= 4'hA;
    repeat (4) @(posedge clk_i);
    rreg(REG_GPIO_IN, d);
    chk("gpio in", d, 32'(gpio_in_i ^ 4'hA));
    rreg(4'hF, d);
    chk("unmapped", d, 32'h0);
    wreg(REG_PANEL, 32'h8);
    press(0);
    n = 0;
    repeat (12)
    begin
      @(posedge clk_i);
      #1;
      n += (midi_led_o === 1'b1) + (confirm_led_o === 1'b1);
    end
    chk("flash", 32'(n > 0 && n < 24), 32'h1);
    press(2);
    chk("cancel", 32'({midi_led_o, confirm_led_o, in_use_led_o}), 32'h0);
    wreg(REG_PANEL, 32'h7);
    press(0);
    press(1);
    repeat (4) @(posedge clk_i);
    #1;
    chk("confirm", 32'(in_use_led_o), 32'h0080);
    do_reset(1'b0);
    req(4'h0, TT_RS232, 1'b0);
    req(4'h2, TT_MIDI_OUT, 1'b1);
    finish_test();
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    fails++;
    finish_test();
  end
endmodule : test_serial_tunnel_switch_config
`default_nettype wire
